// *** verilog/crm_pkg.sv ***
// Shared constants of the CAN receive mask select and buffer status block
package crm_pkg;
    localparam int CRM_ADDR_W = 8;
    localparam int CRM_NUM_FILTERS = 16;
    localparam int CRM_NUM_MASKS = 3;
    localparam int CRM_NUM_BUFFERS = 32;
    localparam int CRM_SID_W = 11;
    localparam int CRM_EID_W = 18;

    // Register byte offsets
    localparam logic [7:0] CRM_OFF_SEL_LOW = 8'h00;
    localparam logic [7:0] CRM_OFF_SEL_HIGH = 8'h04;
    localparam logic [7:0] CRM_OFF_MASK0_SID = 8'h08;
    localparam logic [7:0] CRM_OFF_MASK0_EID = 8'h0c;
    localparam logic [7:0] CRM_OFF_MASK1_SID = 8'h10;
    localparam logic [7:0] CRM_OFF_MASK1_EID = 8'h14;
    localparam logic [7:0] CRM_OFF_MASK2_SID = 8'h18;
    localparam logic [7:0] CRM_OFF_MASK2_EID = 8'h1c;
    localparam logic [7:0] CRM_OFF_FULL_LOW = 8'h20;
    localparam logic [7:0] CRM_OFF_FULL_HIGH = 8'h24;
    localparam logic [7:0] CRM_OFF_OVF_LOW = 8'h28;
    localparam logic [7:0] CRM_OFF_OVF_HIGH = 8'h2c;

    // Field positions in the mask standard identifier register
    localparam int CRM_MSID_SID_LSB = 5;
    localparam int CRM_MSID_FRAME_TYPE_MATCH_ENABLE_BIT = 3;
    localparam int CRM_MSID_EID_LSB = 0;
    localparam logic [15:0] CRM_MSID_IMPL = 16'hffeb;

    // Mask source codes
    localparam logic [1:0] CRM_SRC_MASK0 = 2'h0;
    localparam logic [1:0] CRM_SRC_MASK1 = 2'h1;
    localparam logic [1:0] CRM_SRC_MASK2 = 2'h2;

    // Reset values
    localparam logic [15:0] CRM_RST_SEL = 16'h0000;
    localparam logic [15:0] CRM_RST_MASK = 16'h0000;
    localparam logic [31:0] CRM_RST_FLAGS = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] CRM_RESP_OKAY = 2'h0;
    localparam logic [1:0] CRM_RESP_SLVERR = 2'h2;
endpackage

// *** verilog/crm_filter_match.sv ***
// One acceptance filter compared against one received identifier
module crm_filter_match
    import crm_pkg::*;
(
    input wire logic [CRM_SID_W-1:0] mask_sid_in,
    input wire logic [CRM_EID_W-1:0] mask_eid_in,
    input wire logic frame_type_match_enable_in,
    input wire logic [CRM_SID_W-1:0] filt_sid_in,
    input wire logic [CRM_EID_W-1:0] filt_eid_in,
    input wire logic filter_extended_select_in,
    input wire logic [CRM_SID_W-1:0] msg_sid_in,
    input wire logic [CRM_EID_W-1:0] msg_eid_in,
    input wire logic msg_extended_in,
    output logic hit_out
);
    logic sid_ok;
    logic eid_ok;
    logic type_ok;

    // Only mask-enabled bits take part; filter bit gives the required value
    assign sid_ok = ((msg_sid_in ^ filt_sid_in) & mask_sid_in) == '0;
    assign eid_ok = ((msg_eid_in ^ filt_eid_in) & mask_eid_in) == '0;
    // Type check only when the mask asks for it
    assign type_ok = !frame_type_match_enable_in || (msg_extended_in == filter_extended_select_in);
    // Standard frames compare the standard part, extended frames both parts
    assign hit_out = type_ok && sid_ok && (!msg_extended_in || eid_ok);
endmodule

// *** verilog/crm_flag_bank.sv ***
// Bank of sticky flags set by hardware and cleared by software
module crm_flag_bank
    import crm_pkg::*;
#(
    parameter int WIDTH = CRM_NUM_BUFFERS
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clear_in,
    output logic [WIDTH-1:0] flags_out
);
    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } crm_flag_s;

    crm_flag_s state;
    crm_flag_s next_state;

    always_comb begin
        next_state = state;
        // A set in the same cycle as a clear wins
        next_state.flags = (state.flags & ~clear_in) | set_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state.flags <= WIDTH'(CRM_RST_FLAGS);
        end else begin
            state <= next_state;
        end
    end

    assign flags_out = state.flags;
endmodule

// *** verilog/crm_rx_mask_status.sv ***
// CAN receive mask selection, acceptance masks and buffer full/overflow status
// What this block does
// - Selector 00/01/10 picks mask 0/1/2.
// - Low select register holds filters 7..0.
// - High select register holds filters 15..8.
// - Mask STANDARD_IDENTIFIER_BITS bits 15-5 enable comparison.
// - Mask bits 1-0 enable extended bits 17,16.
// - Mask extended register enables extended bits 15..0.
// - Type-match bit set requires frame type equality.
// - Type-match clear accepts either type on match.
// - Three masks, each STANDARD_IDENTIFIER_BITS and EXTENDED_IDENTIFIER_BITS register.
// - Full set on store; buffers 0..15 low.
// - Buffers 16..31 full flags in high register.
// - Overflow set when storing into full buffer.
// - Flags cleared by writing zero; reset zero.
// - Mask STANDARD_IDENTIFIER_BITS bits 4 and 2 read zero.
// - Filter extended select picks frame type.
// - Filter bit gives required identifier bit value.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
module crm_rx_mask_status
    import crm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // AXI4-Lite slave
    input wire logic [CRM_ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [CRM_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Filter identifier settings from the filter registers
    input wire logic [CRM_NUM_FILTERS*CRM_SID_W-1:0] filter_sid_in,
    input wire logic [CRM_NUM_FILTERS*CRM_EID_W-1:0] filter_eid_in,
    input wire logic [CRM_NUM_FILTERS-1:0] filter_extended_select_in,
    // Received identifier from the protocol engine
    input wire logic msg_valid_in,
    input wire logic [CRM_SID_W-1:0] msg_sid_in,
    input wire logic [CRM_EID_W-1:0] msg_eid_in,
    input wire logic msg_extended_in,
    output logic hit_valid_out,
    output logic [CRM_NUM_FILTERS-1:0] filter_hit_out,
    // Store of a received message into a buffer
    input wire logic store_valid_in,
    input wire logic [4:0] store_buffer_in,
    output logic [CRM_NUM_BUFFERS-1:0] rx_buffer_full_flag_out,
    output logic [CRM_NUM_BUFFERS-1:0] rx_buffer_overflow_flag_out
);
    typedef struct packed {
        logic aw_have;
        logic [CRM_ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] sel_low;
        logic [15:0] sel_high;
        logic [CRM_NUM_MASKS-1:0][15:0] mask_sid;
        logic [CRM_NUM_MASKS-1:0][15:0] mask_eid;
        logic hit_valid;
        logic [CRM_NUM_FILTERS-1:0] hit;
    } crm_state_s;

    crm_state_s state;
    crm_state_s next_state;

    logic [CRM_NUM_BUFFERS-1:0] full_flags;
    logic [CRM_NUM_BUFFERS-1:0] ovf_flags;
    logic [CRM_NUM_BUFFERS-1:0] store_onehot;
    logic [CRM_NUM_BUFFERS-1:0] full_clear;
    logic [CRM_NUM_BUFFERS-1:0] ovf_clear;
    logic [CRM_NUM_FILTERS-1:0] hit_raw;
    logic [31:0] sel_all;

    function automatic logic [15:0] crm_merge(input logic [15:0] old, input logic [15:0] data,
                                              input logic [15:0] lanes);
        crm_merge = (old & ~lanes) | (data & lanes);
    endfunction

    // Eight selectors of two bits per register, filter n at bits 2n+1:2n
    assign sel_all = {state.sel_high, state.sel_low};

    // Per-filter mask selection and comparison
    for (genvar f = 0; f < CRM_NUM_FILTERS; f++) begin : g_filter
        logic [1:0] src;
        logic [15:0] m_sid;
        logic [15:0] m_eid;
        logic raw;
        assign src = sel_all[2*f +: 2];
        // Reserved code selects mask 2 storage but never hits
        assign m_sid = (src == CRM_SRC_MASK0) ? state.mask_sid[0] :
                       (src == CRM_SRC_MASK1) ? state.mask_sid[1] : state.mask_sid[2];
        assign m_eid = (src == CRM_SRC_MASK0) ? state.mask_eid[0] :
                       (src == CRM_SRC_MASK1) ? state.mask_eid[1] : state.mask_eid[2];
        crm_filter_match u_match (
            .mask_sid_in(m_sid[CRM_MSID_SID_LSB +: CRM_SID_W]),
            .mask_eid_in({m_sid[CRM_MSID_EID_LSB +: 2], m_eid}),
            .frame_type_match_enable_in(m_sid[CRM_MSID_FRAME_TYPE_MATCH_ENABLE_BIT]),
            .filt_sid_in(filter_sid_in[f*CRM_SID_W +: CRM_SID_W]),
            .filt_eid_in(filter_eid_in[f*CRM_EID_W +: CRM_EID_W]),
            .filter_extended_select_in(filter_extended_select_in[f]),
            .msg_sid_in(msg_sid_in),
            .msg_eid_in(msg_eid_in),
            .msg_extended_in(msg_extended_in),
            .hit_out(raw)
        );
        assign hit_raw[f] = raw && (src != 2'h3);
    end

    // Store request: full set always, overflow when already full
    assign store_onehot = store_valid_in ? (CRM_NUM_BUFFERS'(1) << store_buffer_in) : '0;

    crm_flag_bank #(
        .WIDTH(CRM_NUM_BUFFERS)
    ) u_full (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .set_in(store_onehot),
        .clear_in(full_clear),
        .flags_out(full_flags)
    );

    crm_flag_bank #(
        .WIDTH(CRM_NUM_BUFFERS)
    ) u_ovf (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .set_in(store_onehot & full_flags),
        .clear_in(ovf_clear),
        .flags_out(ovf_flags)
    );

    always_comb begin
        logic aw_now;
        logic w_now;
        logic [CRM_ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [15:0] lanes;
        logic [15:0] wclr;
        logic do_write;
        logic hit_addr;
        aw_now = 1'b0;
        w_now = 1'b0;
        waddr = '0;
        wdata = '0;
        lanes = '0;
        wclr = '0;
        do_write = 1'b0;
        hit_addr = 1'b1;
        next_state = state;
        full_clear = '0;
        ovf_clear = '0;

        // Write address and data taken in either order
        aw_now = state.aw_have || (s_axi_awvalid_in && state.awready);
        w_now = state.w_have || (s_axi_wvalid_in && state.wready);
        if (s_axi_awvalid_in && state.awready) begin
            next_state.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && state.wready) begin
            next_state.w_data = s_axi_wdata_in;
            next_state.w_strb = s_axi_wstrb_in;
        end
        waddr = state.aw_have ? state.aw_addr : s_axi_awaddr_in;
        wdata = state.w_have ? state.w_data : s_axi_wdata_in;
        lanes = state.w_have ? {{8{state.w_strb[1]}}, {8{state.w_strb[0]}}} :
                               {{8{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}};
        // Zero written into an enabled lane clears that flag
        wclr = lanes & ~wdata[15:0];
        next_state.aw_have = aw_now;
        next_state.w_have = w_now;
        do_write = aw_now && w_now && !state.bvalid;

        if (do_write) begin
            next_state.aw_have = 1'b0;
            next_state.w_have = 1'b0;
            next_state.bvalid = 1'b1;
            unique case (waddr)
                CRM_OFF_SEL_LOW: begin
                    next_state.sel_low = crm_merge(state.sel_low, wdata[15:0], lanes);
                end
                CRM_OFF_SEL_HIGH: begin
                    next_state.sel_high = crm_merge(state.sel_high, wdata[15:0], lanes);
                end
                CRM_OFF_MASK0_SID: begin
                    next_state.mask_sid[0] = crm_merge(state.mask_sid[0], wdata[15:0] & CRM_MSID_IMPL, lanes);
                end
                CRM_OFF_MASK0_EID: begin
                    next_state.mask_eid[0] = crm_merge(state.mask_eid[0], wdata[15:0], lanes);
                end
                CRM_OFF_MASK1_SID: begin
                    next_state.mask_sid[1] = crm_merge(state.mask_sid[1], wdata[15:0] & CRM_MSID_IMPL, lanes);
                end
                CRM_OFF_MASK1_EID: begin
                    next_state.mask_eid[1] = crm_merge(state.mask_eid[1], wdata[15:0], lanes);
                end
                CRM_OFF_MASK2_SID: begin
                    next_state.mask_sid[2] = crm_merge(state.mask_sid[2], wdata[15:0] & CRM_MSID_IMPL, lanes);
                end
                CRM_OFF_MASK2_EID: begin
                    next_state.mask_eid[2] = crm_merge(state.mask_eid[2], wdata[15:0], lanes);
                end
                CRM_OFF_FULL_LOW: begin
                    full_clear[15:0] = wclr;
                end
                CRM_OFF_FULL_HIGH: begin
                    full_clear[31:16] = wclr;
                end
                CRM_OFF_OVF_LOW: begin
                    ovf_clear[15:0] = wclr;
                end
                CRM_OFF_OVF_HIGH: begin
                    ovf_clear[31:16] = wclr;
                end
                default: begin
                    hit_addr = 1'b0;
                end
            endcase
            next_state.bresp = hit_addr ? CRM_RESP_OKAY : CRM_RESP_SLVERR;
        end else if (state.bvalid && s_axi_bready_in) begin
            next_state.bvalid = 1'b0;
        end
        next_state.awready = !next_state.aw_have && !next_state.bvalid;
        next_state.wready = !next_state.w_have && !next_state.bvalid;

        // Read channel: one read under way at a time
        if (s_axi_arvalid_in && state.arready) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = CRM_RESP_OKAY;
            next_state.rdata = '0;
            unique case (s_axi_araddr_in)
                CRM_OFF_SEL_LOW: next_state.rdata[15:0] = state.sel_low;
                CRM_OFF_SEL_HIGH: next_state.rdata[15:0] = state.sel_high;
                CRM_OFF_MASK0_SID: next_state.rdata[15:0] = state.mask_sid[0] & CRM_MSID_IMPL;
                CRM_OFF_MASK0_EID: next_state.rdata[15:0] = state.mask_eid[0];
                CRM_OFF_MASK1_SID: next_state.rdata[15:0] = state.mask_sid[1] & CRM_MSID_IMPL;
                CRM_OFF_MASK1_EID: next_state.rdata[15:0] = state.mask_eid[1];
                CRM_OFF_MASK2_SID: next_state.rdata[15:0] = state.mask_sid[2] & CRM_MSID_IMPL;
                CRM_OFF_MASK2_EID: next_state.rdata[15:0] = state.mask_eid[2];
                CRM_OFF_FULL_LOW: next_state.rdata[15:0] = full_flags[15:0];
                CRM_OFF_FULL_HIGH: next_state.rdata[15:0] = full_flags[31:16];
                CRM_OFF_OVF_LOW: next_state.rdata[15:0] = ovf_flags[15:0];
                CRM_OFF_OVF_HIGH: next_state.rdata[15:0] = ovf_flags[31:16];
                default: next_state.rresp = CRM_RESP_SLVERR;
            endcase
        end else if (state.rvalid && s_axi_rready_in) begin
            next_state.rvalid = 1'b0;
        end
        next_state.arready = !next_state.rvalid;

        // Filter hits registered one cycle after the identifier
        next_state.hit_valid = msg_valid_in;
        if (msg_valid_in) begin
            next_state.hit = hit_raw;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state <= '0;
            state.awready <= 1'b1;
            state.wready <= 1'b1;
            state.arready <= 1'b1;
            state.sel_low <= CRM_RST_SEL;
            state.sel_high <= CRM_RST_SEL;
            state.mask_sid <= {CRM_NUM_MASKS{CRM_RST_MASK}};
            state.mask_eid <= {CRM_NUM_MASKS{CRM_RST_MASK}};
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready_out = state.awready;
    assign s_axi_wready_out = state.wready;
    assign s_axi_bvalid_out = state.bvalid;
    assign s_axi_bresp_out = state.bresp;
    assign s_axi_arready_out = state.arready;
    assign s_axi_rvalid_out = state.rvalid;
    assign s_axi_rresp_out = state.rresp;
    assign s_axi_rdata_out = state.rdata;
    assign hit_valid_out = state.hit_valid;
    assign filter_hit_out = state.hit;
    assign rx_buffer_full_flag_out = full_flags;
    assign rx_buffer_overflow_flag_out = ovf_flags;
endmodule

// *** verification/crm_engine_model.sv ***
// Protocol engine model: presents received identifiers and buffer stores
module crm_engine_model
    import crm_pkg::*;
(
    input wire logic ref_clk_in,
    output logic msg_valid_out,
    output logic [CRM_SID_W-1:0] msg_sid_out,
    output logic [CRM_EID_W-1:0] msg_eid_out,
    output logic msg_extended_out,
    output logic store_valid_out,
    output logic [4:0] store_buffer_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {msg_valid_out, msg_sid_out, msg_eid_out, msg_extended_out} = '0;
        {store_valid_out, store_buffer_out} = '0;
    end
    task automatic send(input logic [CRM_SID_W-1:0] s, input logic [CRM_EID_W-1:0] e, input logic x);
        @(posedge ref_clk_in);
        msg_valid_out <= 1'b1;
        msg_sid_out <= s;
        msg_eid_out <= e;
        msg_extended_out <= x;
        @(posedge ref_clk_in);
        msg_valid_out <= 1'b0;
        // Identifier lines mean nothing between frames
        msg_sid_out <= ~s;
        msg_eid_out <= ~e;
        msg_extended_out <= ~x;
    endtask
    task automatic store(input logic [4:0] b);
        @(posedge ref_clk_in);
        store_valid_out <= 1'b1;
        store_buffer_out <= b;
        @(posedge ref_clk_in);
        store_valid_out <= 1'b0;
        store_buffer_out <= ~b;
    endtask
endmodule

// *** verification/crm_rx_mask_status_props.sv ***
// Concurrent checks on the mask status block ports
module crm_rx_mask_status_props
    import crm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [CRM_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_bvalid_out,
    input wire logic msg_valid_in,
    input wire logic hit_valid_out,
    input wire logic [CRM_NUM_FILTERS-1:0] filter_hit_out,
    input wire logic store_valid_in,
    input wire logic [4:0] store_buffer_in,
    input wire logic [CRM_NUM_BUFFERS-1:0] rx_buffer_full_flag_out,
    input wire logic [CRM_NUM_BUFFERS-1:0] rx_buffer_overflow_flag_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sid_rd;
    logic ovf_hit;
    assign sid_rd = s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in inside
        {CRM_OFF_MASK0_SID, CRM_OFF_MASK1_SID, CRM_OFF_MASK2_SID});
    assign ovf_hit = store_valid_in && rx_buffer_full_flag_out[store_buffer_in];
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    AST_HIT_LAT: assert property (msg_valid_in |=> hit_valid_out) else $error("hit valid late");
    AST_HIT_HOLD: assert property (!msg_valid_in |=> $stable(filter_hit_out)) else $error("hits moved");
    AST_FULL_SET: assert property (store_valid_in |=> rx_buffer_full_flag_out[$past(store_buffer_in)])
        else $error("full flag not set");
    AST_OVF_SET: assert property (ovf_hit |=> rx_buffer_overflow_flag_out[$past(store_buffer_in)])
        else $error("overflow flag not set");
    AST_FULL_CAUSE: assert property (!store_valid_in |=> (rx_buffer_full_flag_out &
        ~$past(rx_buffer_full_flag_out)) == '0) else $error("full flag set alone");
    AST_OVF_CAUSE: assert property (!ovf_hit |=> (rx_buffer_overflow_flag_out &
        ~$past(rx_buffer_overflow_flag_out)) == '0) else $error("overflow flag set alone");
    AST_FLAG_DROP: assert property (((~rx_buffer_full_flag_out & $past(rx_buffer_full_flag_out)) != '0 ||
        (~rx_buffer_overflow_flag_out & $past(rx_buffer_overflow_flag_out)) != '0) |-> $rose(s_axi_bvalid_out))
        else $error("flag cleared without write");
    AST_MSID_ZERO: assert property (sid_rd |=> !s_axi_rdata_out[4] && !s_axi_rdata_out[2])
        else $error("unused mask bits read high");
endmodule
bind crm_rx_mask_status crm_rx_mask_status_props crm_rx_mask_status_props_inst (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .msg_valid_in(msg_valid_in), .hit_valid_out(hit_valid_out), .filter_hit_out(filter_hit_out),
    .store_valid_in(store_valid_in), .store_buffer_in(store_buffer_in),
    .rx_buffer_full_flag_out(rx_buffer_full_flag_out), .rx_buffer_overflow_flag_out(rx_buffer_overflow_flag_out));

// *** verification/crm_rx_mask_status_bench.sv ***
// Self-checking bench of the mask status block
module crm_rx_mask_status_bench
    import crm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] WV [3] = '{16'hffe0, 16'hffff, 16'h801c};
    localparam logic [10:0] MS [5] = '{11'h2a5, 11'h2a5, 11'h2a5, 11'h3a5, 11'h6a5};
    localparam logic [17:0] ME [5] = '{18'h15a5a, 18'h15a5a, 18'h05a5a, 18'h0, 18'h0};
    localparam logic [4:0] MX = 5'b00110;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'h3;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, hit_valid, mv, mx, sv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, full, ovf;
    logic [15:0] fhit, fes = 16'h0202;
    logic [10:0] ms;
    logic [17:0] me;
    logic [4:0] sb;
    logic [15:0] msid [3], meid [3], sel [2];
    int fails = 0, checks_done = 0, cyc = 0;
    crm_rx_mask_status crm_rx_mask_status_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .filter_sid_in({16{11'h2a5}}), .filter_eid_in({16{18'h15a5a}}), .filter_extended_select_in(fes),
        .msg_valid_in(mv), .msg_sid_in(ms), .msg_eid_in(me), .msg_extended_in(mx), .hit_valid_out(hit_valid),
        .filter_hit_out(fhit), .store_valid_in(sv), .store_buffer_in(sb),
        .rx_buffer_full_flag_out(full), .rx_buffer_overflow_flag_out(ovf));
    crm_engine_model crm_engine_model_inst (.ref_clk_in(ref_clk_in), .msg_valid_out(mv), .msg_sid_out(ms),
        .msg_eid_out(me), .msg_extended_out(mx), .store_valid_out(sv), .store_buffer_out(sb));
    always #10 ref_clk_in = ~ref_clk_in;
    task automatic complete_run();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails = fails + 1;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        @(posedge ref_clk_in);
        awaddr <= a;
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge ref_clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    // Expected hits from mask selection, masks and frame type
    function automatic logic [15:0] exp_hit(logic [10:0] s, logic [17:0] e, logic x);
        logic [15:0] h;
        logic [1:0] c;
        h = '0;
        for (int f = 0; f < 16; f++) begin
            c = sel[f / 8][2 * (f % 8) +: 2];
            if (c != 2'h3 && (!msid[c][3] || x == fes[f]) && ((s ^ 11'h2a5) & msid[c][15:5]) == '0
                && (!x || ((e ^ 18'h15a5a) & {msid[c][1:0], meid[c]}) == '0)) h[f] = 1'b1;
        end
        return h;
    endfunction
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 12; i++) rd(8'(4 * i), 32'h0, CRM_RESP_OKAY);
        rd(8'h30, 32'h0, CRM_RESP_SLVERR);
        wr(8'h30, 16'hffff, CRM_RESP_SLVERR);
        for (int i = 0; i < 3; i++) begin
            msid[i] = WV[i] & 16'hffeb;
            meid[i] = (i == 1) ? 16'hffff : 16'h0000;
            wr(CRM_OFF_MASK0_SID + 8'(8 * i), WV[i], CRM_RESP_OKAY);
            wr(CRM_OFF_MASK0_EID + 8'(8 * i), meid[i], CRM_RESP_OKAY);
            rd(CRM_OFF_MASK0_SID + 8'(8 * i), {16'h0, msid[i]}, CRM_RESP_OKAY);
            rd(CRM_OFF_MASK0_EID + 8'(8 * i), {16'h0, meid[i]}, CRM_RESP_OKAY);
        end
        sel = '{16'he4e4, 16'h1b1b};
        wr(CRM_OFF_SEL_LOW, sel[0], CRM_RESP_OKAY);
        wr(CRM_OFF_SEL_HIGH, sel[1], CRM_RESP_OKAY);
        rd(CRM_OFF_SEL_LOW, {16'h0, sel[0]}, CRM_RESP_OKAY);
        rd(CRM_OFF_SEL_HIGH, {16'h0, sel[1]}, CRM_RESP_OKAY);
        // Upper byte lane only: lower selectors must stay as written
        wstrb <= 4'h2;
        wr(CRM_OFF_SEL_LOW, 16'h0000, CRM_RESP_OKAY);
        wstrb <= 4'h3;
        rd(CRM_OFF_SEL_LOW, {16'h0, 8'h00, sel[0][7:0]}, CRM_RESP_OKAY);
        wr(CRM_OFF_SEL_LOW, sel[0], CRM_RESP_OKAY);
        rd(CRM_OFF_SEL_LOW, {16'h0, sel[0]}, CRM_RESP_OKAY);
        for (int k = 0; k < 5; k++) begin
            crm_engine_model_inst.send(MS[k], ME[k], MX[k]);
            #1;
            chk("hit_valid", 32'h1, {31'h0, hit_valid});
            chk("filter_hit", {16'h0, exp_hit(MS[k], ME[k], MX[k])}, {16'h0, fhit});
        end
        crm_engine_model_inst.store(5'd5);
        crm_engine_model_inst.store(5'd20);
        crm_engine_model_inst.store(5'd5);
        crm_engine_model_inst.store(5'd20);
        #1;
        chk("full", 32'h0010_0020, full);
        chk("ovf", 32'h0010_0020, ovf);
        rd(CRM_OFF_FULL_LOW, 32'h20, CRM_RESP_OKAY);
        rd(CRM_OFF_FULL_HIGH, 32'h10, CRM_RESP_OKAY);
        rd(CRM_OFF_OVF_LOW, 32'h20, CRM_RESP_OKAY);
        rd(CRM_OFF_OVF_HIGH, 32'h10, CRM_RESP_OKAY);
        wr(CRM_OFF_FULL_LOW, 16'hffff, CRM_RESP_OKAY);
        rd(CRM_OFF_FULL_LOW, 32'h20, CRM_RESP_OKAY);
        wr(CRM_OFF_FULL_LOW, 16'hffdf, CRM_RESP_OKAY);
        wr(CRM_OFF_OVF_HIGH, 16'hffef, CRM_RESP_OKAY);
        rd(CRM_OFF_FULL_LOW, 32'h0, CRM_RESP_OKAY);
        rd(CRM_OFF_OVF_HIGH, 32'h0, CRM_RESP_OKAY);
        #1;
        chk("flags", 32'h0010_0020, {full[31:16], ovf[15:0]});
        complete_run();
    end
endmodule
